// ### pkg/tmr_pkg.sv
// constants shared by the eight-bit timer block: register offsets, field
// positions, reset values and cycle counts.
// assumes clk_i is the oscillator clock; four of its cycles make one
// instruction cycle.
package tmr_pkg;

	// ------------------------------------------------------------------
	// clocking
	// ------------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 50_000_000;
	localparam int OSC_PER_INST = 4;
	localparam int INHIBIT_INST_CYCLES = 2;
	localparam int CNT_W = 8;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_COUNT = 4'h0;
	localparam logic [3:0] OFS_OPTION = 4'h1;
	localparam logic [3:0] OFS_IRQ_CONTROL = 4'h2;

	// ------------------------------------------------------------------
	// option register fields
	// ------------------------------------------------------------------
	localparam int BIT_SOURCE_SELECT = 5;
	localparam int BIT_EDGE_SELECT = 4;
	localparam int BIT_PRESCALER_BYPASS = 3;
	localparam int BIT_RATE_HI = 2;
	localparam int BIT_RATE_LO = 0;
	localparam logic [7:0] OPTION_RESET = 8'hff;

	// ------------------------------------------------------------------
	// interrupt control register fields
	// ------------------------------------------------------------------
	localparam int BIT_OVERFLOW_IRQ_ENABLE = 5;
	localparam int BIT_OVERFLOW_FLAG = 2;
	localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;

endpackage

// ### logic/prescale_divider.sv
// shared-free prescaler for the eight-bit timer: divides a pulse stream by
// two to the power of (rate + 1), or passes it through when bypassed.
// assumes src_i is a one-cycle pulse on clk_i.
`timescale 1ns/1ps
module prescale_divider #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic clear_i,
	input wire logic bypass_i,
	input wire logic [2:0] rate_i,
	// pulses
	input wire logic src_i,
	output logic tick_o
);

	logic [WIDTH-1:0] cnt_q;
	logic at_end;

	function automatic logic [WIDTH-1:0] rate_mask(input logic [2:0] r);
		rate_mask = WIDTH'((16'h0002 << r) - 16'h0001);
	endfunction

	// a lowered rate may leave the count above the new end; >= ends it at once
	assign at_end = cnt_q >= rate_mask(rate_i);
	assign tick_o = bypass_i ? src_i : (src_i && at_end);

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			cnt_q <= '0;
		end else if (src_i && !bypass_i) begin
			cnt_q <= at_end ? '0 : cnt_q + 1'b1;
		end
	end

	AST_PRESC_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_i |=> cnt_q == '0)
		else $error("prescaler not cleared after count write");

	AST_PRESC_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_o && !bypass_i) |-> (cnt_q >= rate_mask(rate_i)))
		else $error("prescaler ticked before its ratio");

endmodule // prescale_divider

// ### logic/eight_bit_timer.sv
// eight-bit timer/counter with prescaler, overflow flag and irq request.
// assumes clk_i is the oscillator, the register port is driven on clk_i,
// sleep_i comes from logic on clk_i and ext_count_pin_i is asynchronous.
//
// Notes on behaviour
// - unscaled timer mode: one per instruction cycle
// - timer source is oscillator over four
// - source select clear: timer; set: pin
// - count write blocks increments two instruction cycles
// - counter mode counts selected pin edge
// - edge select one falling, zero rising
// - pin edges synchronised before counting
// - bypass clear inserts prescaler; set gives 1:1
// - eight ratios from 1:2 to 1:256
// - rate code is power of two
// - prescaler count hidden from software
// - count write clears the prescaler
// - wrap from ff to 00 signals overflow
// - flag sets regardless of irq enable
// - only software clears the overflow flag
// - irq request only while enable set
// - sleep freezes count, no overflow wake
// - prescaler belongs to this timer only
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module eight_bit_timer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// pins and system
	input wire logic ext_count_pin_i,
	input wire logic sleep_i,
	// status
	output logic irq_o,
	output logic overflow_o
);

	// ------------------------------------------------------------------
	// registers and decode
	// ------------------------------------------------------------------
	logic [7:0] count_register_q;
	logic [7:0] option_q;
	logic overflow_irq_enable_q;
	logic overflow_flag_q;
	logic [7:0] rdata_q;
	logic overflow_q;

	logic count_wr;
	logic option_wr;
	logic irq_wr;
	logic source_select;
	logic edge_select;
	logic prescaler_bypass;
	logic [2:0] prescale_rate;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	assign count_wr = wr_i && hit(addr_i, tmr_pkg::OFS_COUNT);
	assign option_wr = wr_i && hit(addr_i, tmr_pkg::OFS_OPTION);
	assign irq_wr = wr_i && hit(addr_i, tmr_pkg::OFS_IRQ_CONTROL);

	assign source_select = option_q[tmr_pkg::BIT_SOURCE_SELECT];
	assign edge_select = option_q[tmr_pkg::BIT_EDGE_SELECT];
	assign prescaler_bypass = option_q[tmr_pkg::BIT_PRESCALER_BYPASS];
	assign prescale_rate = option_q[tmr_pkg::BIT_RATE_HI:tmr_pkg::BIT_RATE_LO];

	// ------------------------------------------------------------------
	// instruction cycle
	// ------------------------------------------------------------------
	localparam logic [1:0] PHASE_LAST = 2'(tmr_pkg::OSC_PER_INST - 1);
	logic [1:0] phase_q;
	logic inst_tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= (phase_q == PHASE_LAST) ? 2'h0 : phase_q + 2'h1;
		end
	end

	assign inst_tick = (phase_q == PHASE_LAST);

	// ------------------------------------------------------------------
	// external pin synchroniser and edge select
	// ------------------------------------------------------------------
	logic pin_meta_q;
	logic pin_sync_q;
	logic pin_prev_q;
	logic pin_rise;
	logic pin_fall;
	logic pin_edge;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= ext_count_pin_i;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign pin_rise = pin_sync_q && !pin_prev_q;
	assign pin_fall = !pin_sync_q && pin_prev_q;
	assign pin_edge = edge_select ? pin_fall : pin_rise;

	// ------------------------------------------------------------------
	// count source and prescaler
	// ------------------------------------------------------------------
	logic raw_src;
	logic presc_tick;

	// sleep stops the source itself, so nothing downstream can move
	assign raw_src = !sleep_i && (source_select ? pin_edge : inst_tick);

	// this divider serves the timer alone
	prescale_divider #(
		.WIDTH(tmr_pkg::CNT_W)
	) u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(count_wr),
		.bypass_i(prescaler_bypass),
		.rate_i(prescale_rate),
		.src_i(raw_src),
		.tick_o(presc_tick)
	);

	// ------------------------------------------------------------------
	// write inhibit
	// ------------------------------------------------------------------
	localparam logic [1:0] INHIBIT_LOAD = 2'(tmr_pkg::INHIBIT_INST_CYCLES);
	logic [1:0] inhibit_q;
	logic count_inc;

	// prescaled ticks landing in the inhibit window are dropped, not deferred
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit_q <= 2'h0;
		end else if (count_wr) begin
			inhibit_q <= INHIBIT_LOAD;
		end else if (inst_tick && !sleep_i && inhibit_q != 2'h0) begin
			inhibit_q <= inhibit_q - 2'h1;
		end
	end

	assign count_inc = presc_tick && (inhibit_q == 2'h0) && !count_wr;

	// ------------------------------------------------------------------
	// counter and overflow
	// ------------------------------------------------------------------
	logic wrap;

	assign wrap = count_inc && (count_register_q == 8'hff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_register_q <= tmr_pkg::COUNT_RESET;
		end else if (count_wr) begin
			count_register_q <= wdata_i;
		end else if (count_inc) begin
			count_register_q <= count_register_q + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_q <= 1'b0;
		end else begin
			overflow_q <= wrap;
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			option_q <= tmr_pkg::OPTION_RESET;
		end else if (option_wr) begin
			option_q <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_irq_enable_q <= tmr_pkg::IRQ_CONTROL_RESET[tmr_pkg::BIT_OVERFLOW_IRQ_ENABLE];
		end else if (irq_wr) begin
			overflow_irq_enable_q <= wdata_i[tmr_pkg::BIT_OVERFLOW_IRQ_ENABLE];
		end
	end

	// a wrap in the same cycle as a clearing write keeps the flag set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag_q <= tmr_pkg::IRQ_CONTROL_RESET[tmr_pkg::BIT_OVERFLOW_FLAG];
		end else if (wrap) begin
			overflow_flag_q <= 1'b1;
		end else if (irq_wr) begin
			overflow_flag_q <= wdata_i[tmr_pkg::BIT_OVERFLOW_FLAG];
		end
	end

	// ------------------------------------------------------------------
	// read port
	// ------------------------------------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (addr_i)
			tmr_pkg::OFS_COUNT: begin
				rd_mux = count_register_q;
			end
			tmr_pkg::OFS_OPTION: begin
				rd_mux = option_q;
			end
			tmr_pkg::OFS_IRQ_CONTROL: begin
				rd_mux[tmr_pkg::BIT_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable_q;
				rd_mux[tmr_pkg::BIT_OVERFLOW_FLAG] = overflow_flag_q;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_i ? rd_mux : 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign rdata_o = rdata_q;
	assign irq_o = overflow_flag_q && overflow_irq_enable_q;
	assign overflow_o = overflow_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_count_write;
		count_wr;
	endsequence

	sequence s_quiet_after_write;
		!count_inc [*5];
	endsequence

	sequence s_wrap_seen;
		wrap ##1 (count_register_q == 8'h00);
	endsequence

	AST_TIMER_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
		(!source_select && prescaler_bypass && !sleep_i && inst_tick
			&& inhibit_q == 2'h0 && !count_wr)
		|=> count_register_q == $past(count_register_q) + 8'h01)
		else $error("timer mode did not step on instruction cycle");

	AST_TIMER_SOURCE: assert property (@(posedge clk_i) disable iff (rst_i)
		(!source_select && raw_src) |-> inst_tick ##1 (!inst_tick [*3]) ##1 inst_tick)
		else $error("timer source not every fourth clock");

	AST_SOURCE_SELECT: assert property (@(posedge clk_i) disable iff (rst_i)
		(source_select && !pin_edge) |-> !raw_src)
		else $error("counter mode counted without a pin edge");

	AST_WRITE_INHIBIT: assert property (@(posedge clk_i) disable iff (rst_i)
		s_count_write |=> s_quiet_after_write)
		else $error("count moved inside the write inhibit");

	AST_FALL_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
		(source_select && edge_select && raw_src)
		|-> (!$past(ext_count_pin_i, 2) && $past(ext_count_pin_i, 3)))
		else $error("falling edge mode took a wrong edge");

	AST_RISE_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
		(source_select && !edge_select && raw_src)
		|-> ($past(ext_count_pin_i, 2) && !$past(ext_count_pin_i, 3)))
		else $error("rising edge mode took a wrong edge");

	AST_BYPASS_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(prescaler_bypass && raw_src && inhibit_q == 2'h0 && !count_wr)
		|-> count_inc)
		else $error("bypassed prescaler dropped a source pulse");

	AST_OVERFLOW: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wrap_seen |-> overflow_flag_q && overflow_o)
		else $error("wrap did not raise the overflow flag");

	AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
		(overflow_flag_q && !irq_wr) |=> overflow_flag_q)
		else $error("overflow flag dropped without software");

	AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_o |-> overflow_irq_enable_q) and (wrap |=> (irq_o == overflow_irq_enable_q)))
		else $error("irq request not gated by enable");

	AST_SLEEP_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
		(sleep_i && !count_wr) |=> $stable(count_register_q) && !overflow_o)
		else $error("count moved during sleep");

	AST_PRESC_HIDDEN: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i > tmr_pkg::OFS_IRQ_CONTROL) |=> rdata_o == 8'h00)
		else $error("unmapped read returned data");

endmodule // eight_bit_timer

// ### test/edge_source.sv
// behavioural source of edges on the external count pin.
// assumes go_i is a one-cycle request on clk_i; the pin stands still between bursts.
`timescale 1ns/1ps
module edge_source (
	// clock
	input wire logic clk_i,
	// request
	input wire logic go_i,
	input wire logic [7:0] toggles_i,
	input wire logic [7:0] half_i,
	// pin and status
	output logic pin_o,
	output logic busy_o
);
	int i;

	// ------------------------------------------------------------------
	// burst generator
	// ------------------------------------------------------------------
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i === 1'b1) begin
				busy_o <= 1'b1;
				for (i = 0; i < toggles_i; i++) begin
					// each level held well past two clocks so the synchroniser sees it
					repeat (half_i) @(posedge clk_i);
					pin_o <= ~pin_o;
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule // edge_source

// ### test/eight_bit_timer_tb.sv
// self-checking bench for the eight-bit timer.
// assumes the register port answers reads one cycle later and never waits.
`timescale 1ns/1ps
module eight_bit_timer_tb;
	logic clk_i, rst_i, wr_i, rd_i, pin, sleep_i, irq_o, overflow_o, go, busy;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o, toggles;
	int error_cnt, compares;

	eight_bit_timer eight_bit_timer_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ext_count_pin_i(pin), .sleep_i(sleep_i), .irq_o(irq_o), .overflow_o(overflow_o));
	edge_source edge_source_i (.clk_i(clk_i), .go_i(go), .toggles_i(toggles),
		.half_i(8'h05), .pin_o(pin), .busy_o(busy));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// returns at the first cycle showing the overflow pulse, or after lim cycles
	task automatic wait_ovf(input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (overflow_o !== 1'b1 && n < lim);
	endtask

	task automatic burst(input logic [7:0] n);
		int k;
		k = 0;
		@(posedge clk_i);
		toggles <= n;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		#1;
		while (busy !== 1'b0 && k < 500) begin
			@(posedge clk_i);
			#1 k++;
		end
	endtask

	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_values;
		logic [7:0] d;
		logic [4:0] a;
		rd(tmr_pkg::OFS_COUNT, d);
		check(d, tmr_pkg::COUNT_RESET);
		rd(tmr_pkg::OFS_OPTION, d);
		check(d, tmr_pkg::OPTION_RESET);
		rd(tmr_pkg::OFS_IRQ_CONTROL, d);
		check(d, tmr_pkg::IRQ_CONTROL_RESET);
		check(irq_o, 1'b0);
		// unmapped places hide the prescaler and anything else
		for (a = 5'h03; a <= 5'h0f; a++) begin
			wr(a[3:0], 8'h5a);
			rd(a[3:0], d);
			check(d, 8'h00);
		end
		rd(tmr_pkg::OFS_COUNT, d);
		check(d, 8'h00);
	endtask

	task automatic t_timer_rate;
		logic [7:0] a, b;
		wr(tmr_pkg::OFS_OPTION, 8'h08);
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		rd(tmr_pkg::OFS_COUNT, a);
		check(a, 8'h00);
		tick(16);
		rd(tmr_pkg::OFS_COUNT, a);
		// two of the four or five instruction cycles are swallowed
		check(a == 8'd2 || a == 8'd3, 1'b1);
		tick(38);
		rd(tmr_pkg::OFS_COUNT, b);
		check(b - a, 8'd10);
	endtask

	task automatic t_prescale;
		logic [7:0] a, b;
		logic [3:0] r;
		for (r = 4'h0; r <= 4'h7; r++) begin
			wr(tmr_pkg::OFS_OPTION, {5'h00, r[2:0]});
			wr(tmr_pkg::OFS_COUNT, 8'h00);
			tick(20);
			rd(tmr_pkg::OFS_COUNT, a);
			tick(8 * (2 << r) - 2);
			rd(tmr_pkg::OFS_COUNT, b);
			check(b - a, 8'd2);
		end
		wr(tmr_pkg::OFS_OPTION, 8'h07);
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		tick(800);
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		tick(400);
		rd(tmr_pkg::OFS_COUNT, a);
		check(a, 8'h00);
	endtask

	task automatic t_overflow;
		logic [7:0] d;
		int n;
		wr(tmr_pkg::OFS_IRQ_CONTROL, 8'h00);
		wr(tmr_pkg::OFS_OPTION, 8'h08);
		wr(tmr_pkg::OFS_COUNT, 8'hfd);
		wait_ovf(40, n);
		check(overflow_o, 1'b1);
		// three steps after two inhibited instruction cycles, any tick phase
		check(16'(n >= 17 && n <= 20), 16'h0001);
		check(irq_o, 1'b0);
		tick(1);
		check(overflow_o, 1'b0);
		rd(tmr_pkg::OFS_IRQ_CONTROL, d);
		check(d, 8'h04);
		wr(tmr_pkg::OFS_IRQ_CONTROL, 8'h20);
		rd(tmr_pkg::OFS_IRQ_CONTROL, d);
		check(d, 8'h20);
		check(irq_o, 1'b0);
		wait_ovf(1100, n);
		wait_ovf(1100, n);
		check(16'(n), 16'd1024);
		check(irq_o, 1'b1);
		tick(100);
		rd(tmr_pkg::OFS_IRQ_CONTROL, d);
		check(d, 8'h24);
		wr(tmr_pkg::OFS_IRQ_CONTROL, 8'h00);
	endtask

	task automatic t_sleep;
		logic [7:0] d;
		int n;
		wr(tmr_pkg::OFS_COUNT, 8'hfe);
		sleep_i <= 1'b1;
		wait_ovf(300, n);
		check(overflow_o, 1'b0);
		rd(tmr_pkg::OFS_COUNT, d);
		check(d, 8'hfe);
		@(posedge clk_i);
		sleep_i <= 1'b0;
		wait_ovf(40, n);
		check(overflow_o, 1'b1);
	endtask

	// odd bursts leave the pin on the other level, so the edge kinds differ in number
	task automatic t_counter;
		logic [7:0] d;
		wr(tmr_pkg::OFS_OPTION, 8'h38);
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		tick(20);
		burst(8'd3);
		tick(10);
		rd(tmr_pkg::OFS_COUNT, d);
		check(d, 8'd1);
		wr(tmr_pkg::OFS_OPTION, 8'h28);
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		tick(20);
		burst(8'd5);
		tick(10);
		rd(tmr_pkg::OFS_COUNT, d);
		check(d, 8'd2);
	endtask

	// ------------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// the whole sequence needs about 8300 cycles
	initial begin
		#1_000_000;
		error_cnt++;
		complete_run;
	end

	initial begin
		{wr_i, rd_i, sleep_i, go} = 4'h0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		toggles = 8'h00;
		error_cnt = 0;
		compares = 0;
		do_reset;
		t_reset_values;
		t_timer_rate;
		t_prescale;
		t_overflow;
		t_sleep;
		t_counter;
		#1;
		do_reset;
		t_reset_values;
		complete_run;
	end
endmodule // eight_bit_timer_tb
